// >>> hw/port_function_select_pkg.sv
// port_function_select_pkg: register map, reset values, pin positions and mode decode
// assumes: special-function register bus with 8-bit addresses, one core clock

package port_function_select_pkg;

   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [7:0] FIRST_PORT_SELECT_LOW_ADDR = 8'h8e;
   localparam logic [7:0] FIRST_PORT_SELECT_HIGH_ADDR = 8'h8f;
   localparam logic [7:0] THIRD_PORT_SELECT_ADDR = 8'h91;
   localparam logic [7:0] FOURTH_PORT_SELECT_LOW_ADDR = 8'h92;
   localparam logic [7:0] FOURTH_PORT_SELECT_HIGH_ADDR = 8'h93;
   localparam logic [7:0] SELECT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // level a peripheral sees on an input that is not routed to it
   localparam logic ALT_IDLE_LEVEL = 1'b1;

   // -------------------------------------------------------------
   // pin positions, third port (alternate)
   // -------------------------------------------------------------
   localparam int UART_A_RECEIVE_PIN = 0;
   localparam int UART_A_TRANSMIT_PIN = 1;
   localparam int EXT_IRQ_A_GATE_PIN = 2;
   localparam int EXT_IRQ_B_GATE_PIN = 3;
   localparam int COUNTER_A_INPUT_PIN = 4;
   localparam int COUNTER_B_INPUT_PIN = 5;
   localparam int TWO_WIRE_DATA_PIN = 6;
   localparam int TWO_WIRE_CLOCK_PIN = 7;

   // -------------------------------------------------------------
   // pin positions, shared set (first port alt one, fourth port alt two)
   // -------------------------------------------------------------
   localparam int TIMER_TWO_COUNT_IN_PIN = 0;
   localparam int TIMER_TWO_TRIGGER_IN_PIN = 1;
   localparam int UART_B_RECEIVE_PIN = 2;
   localparam int UART_B_TRANSMIT_PIN = 3;
   localparam int SERIAL_PERIPH_CLOCK_PIN = 4;
   localparam int SERIAL_PERIPH_RECEIVE_PIN = 5;
   localparam int SERIAL_PERIPH_TRANSMIT_PIN = 6;
   localparam int SERIAL_PERIPH_SELECT_PIN = 7;

   // -------------------------------------------------------------
   // pin positions, fourth port alternate one
   // -------------------------------------------------------------
   localparam int COUNTER_ARRAY_A_EXT_CLOCK_PIN = 3;
   localparam int COUNTER_ARRAY_B_EXT_CLOCK_PIN = 7;

   typedef enum logic [1:0] {
      MODE_GPIO,
      MODE_ALT1,
      MODE_ALT2
   } pin_mode_t;

   // low bit clear means general-purpose whatever the high bit holds
   function automatic pin_mode_t decode_mode(input logic sel_lo, input logic sel_hi);
      if (!sel_lo) begin
         return MODE_GPIO;
      end
      else if (!sel_hi) begin
         return MODE_ALT1;
      end
      return MODE_ALT2;
   endfunction

endpackage

// >>> hw/port_route.sv
// port_route: per-pin routing of one 8-bit port between pin, GPIO and two alternates
// assumes: pin input already synchronised; selects come from registers on the same clock

`timescale 1ns/1ps

module port_route (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // selects
   input wire logic [7:0] sel_lo_in,
   input wire logic [7:0] sel_hi_in,
   // pin side
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe_out,
   // general-purpose side
   input wire logic [7:0] gpio_out_in,
   input wire logic [7:0] gpio_oe_in,
   output logic [7:0] gpio_in_out,
   // alternate one
   input wire logic [7:0] a1_out_in,
   input wire logic [7:0] a1_oe_in,
   output logic [7:0] a1_in_out,
   // alternate two
   input wire logic [7:0] a2_out_in,
   input wire logic [7:0] a2_oe_in,
   output logic [7:0] a2_in_out,
   output logic [7:0] a2_active_out
);

   logic [7:0] out_nxt;
   logic [7:0] oe_nxt;
   logic [7:0] a1_in_nxt;
   logic [7:0] a2_in_nxt;
   logic [7:0] a2_act_nxt;

   // -------------------------------------------------------------
   // per-pin selection
   // -------------------------------------------------------------
   genvar i;
   for (i = 0; i < 8; i++) begin : g_pin
      port_function_select_pkg::pin_mode_t mode;
      logic is_a1;
      logic is_a2;
      // R10: each pin decoded alone
      assign mode = port_function_select_pkg::decode_mode(sel_lo_in[i], sel_hi_in[i]);
      assign is_a1 = (mode == port_function_select_pkg::MODE_ALT1);
      assign is_a2 = (mode == port_function_select_pkg::MODE_ALT2);
      assign out_nxt[i] = is_a1 ? a1_out_in[i] : (is_a2 ? a2_out_in[i] : gpio_out_in[i]);
      assign oe_nxt[i] = is_a1 ? a1_oe_in[i] : (is_a2 ? a2_oe_in[i] : gpio_oe_in[i]);
      assign a1_in_nxt[i] = is_a1 ? pin_in[i] : port_function_select_pkg::ALT_IDLE_LEVEL;
      assign a2_in_nxt[i] = is_a2 ? pin_in[i] : port_function_select_pkg::ALT_IDLE_LEVEL;
      assign a2_act_nxt[i] = is_a2;
   end

   // -------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_out <= 8'h00;
         pin_oe_out <= 8'h00;
         gpio_in_out <= 8'hff;
         a1_in_out <= 8'hff;
         a2_in_out <= 8'hff;
         a2_active_out <= 8'h00;
      end
      else begin
         pin_out <= out_nxt;
         pin_oe_out <= oe_nxt;
         gpio_in_out <= pin_in;
         a1_in_out <= a1_in_nxt;
         a2_in_out <= a2_in_nxt;
         a2_active_out <= a2_act_nxt;
      end
   end

endmodule

// >>> hw/port_function_select_mux.sv
// port_function_select_mux: select registers and pin routing for three 8-bit ports
// assumes: register bus on the core clock; pins arrive asynchronously and are synchronised here
//
// Contract
// R1: third port, select bit clear gives GPIO, set gives its single alternate.
// R2: third port alternates: uart a, irq/gates, counters, two-wire data and clock.
// R3: first port, low clear gives GPIO; low only alt one; both alt two.
// R4: first port alt one: timer two, uart b, serial peripheral pins in order.
// R5: first port alt two routes pin i to analog channel i.
// R6: fourth port uses the same two-bit selection as the first port.
// R7: fourth port alt one: counter array modules and external clocks.
// R8: fourth port alt two: timer two, uart b, serial peripheral pins.
// R9: every select register resets to zero, so all pins start as GPIO.
// R10: each pin's selection is independent of every other pin.
// R11: selects read back last write; routing changes from the writing edge (here the registered routing outputs change one edge later).

`timescale 1ns/1ps

module port_function_select_mux (
   // clock and reset
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   // register bus
   input wire logic [7:0] SFR_ADDR_IN,
   input wire logic SFR_WR_IN,
   input wire logic SFR_RD_IN,
   input wire logic [7:0] SFR_WDATA_IN,
   output logic [7:0] SFR_RDATA_OUT,
   // first port pins and users
   input wire logic [7:0] PIN1_IN,
   output logic [7:0] PIN1_OUT,
   output logic [7:0] PIN1_OE_OUT,
   input wire logic [7:0] GPIO1_OUT_IN,
   input wire logic [7:0] GPIO1_OE_IN,
   output logic [7:0] GPIO1_PIN_OUT,
   input wire logic [7:0] ALT1A_OUT_IN,
   input wire logic [7:0] ALT1A_OE_IN,
   output logic [7:0] ALT1A_PIN_OUT,
   output logic [7:0] ANALOG_CHANNEL_EN_OUT,
   // third port pins and users
   input wire logic [7:0] PIN3_IN,
   output logic [7:0] PIN3_OUT,
   output logic [7:0] PIN3_OE_OUT,
   input wire logic [7:0] GPIO3_OUT_IN,
   input wire logic [7:0] GPIO3_OE_IN,
   output logic [7:0] GPIO3_PIN_OUT,
   input wire logic [7:0] ALT3_OUT_IN,
   input wire logic [7:0] ALT3_OE_IN,
   output logic [7:0] ALT3_PIN_OUT,
   // fourth port pins and users
   input wire logic [7:0] PIN4_IN,
   output logic [7:0] PIN4_OUT,
   output logic [7:0] PIN4_OE_OUT,
   input wire logic [7:0] GPIO4_OUT_IN,
   input wire logic [7:0] GPIO4_OE_IN,
   output logic [7:0] GPIO4_PIN_OUT,
   input wire logic [7:0] ALT4A_OUT_IN,
   input wire logic [7:0] ALT4A_OE_IN,
   output logic [7:0] ALT4A_PIN_OUT,
   input wire logic [7:0] ALT4B_OUT_IN,
   input wire logic [7:0] ALT4B_OE_IN,
   output logic [7:0] ALT4B_PIN_OUT
);

   // -------------------------------------------------------------
   // reset release and pin synchronisers
   // -------------------------------------------------------------
   logic rst_meta_r;
   logic rst_n;
   logic [23:0] pin_meta_r;
   logic [23:0] pin_sync_r;

   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_r <= 24'hffffff;
         pin_sync_r <= 24'hffffff;
      end
      else begin
         pin_meta_r <= {PIN4_IN, PIN3_IN, PIN1_IN};
         pin_sync_r <= pin_meta_r;
      end
   end

   // -------------------------------------------------------------
   // select registers
   // -------------------------------------------------------------
   logic [7:0] first_port_select_low_r;
   logic [7:0] first_port_select_high_r;
   logic [7:0] third_port_select_r;
   logic [7:0] fourth_port_select_low_r;
   logic [7:0] fourth_port_select_high_r;
   logic [7:0] rdata_nxt;
   logic hit_p1lo;
   logic hit_p1hi;
   logic hit_p3;
   logic hit_p4lo;
   logic hit_p4hi;

   assign hit_p1lo = (SFR_ADDR_IN == port_function_select_pkg::FIRST_PORT_SELECT_LOW_ADDR);
   assign hit_p1hi = (SFR_ADDR_IN == port_function_select_pkg::FIRST_PORT_SELECT_HIGH_ADDR);
   assign hit_p3 = (SFR_ADDR_IN == port_function_select_pkg::THIRD_PORT_SELECT_ADDR);
   assign hit_p4lo = (SFR_ADDR_IN == port_function_select_pkg::FOURTH_PORT_SELECT_LOW_ADDR);
   assign hit_p4hi = (SFR_ADDR_IN == port_function_select_pkg::FOURTH_PORT_SELECT_HIGH_ADDR);

   assign rdata_nxt = hit_p1lo ? first_port_select_low_r :
                      hit_p1hi ? first_port_select_high_r :
                      hit_p3 ? third_port_select_r :
                      hit_p4lo ? fourth_port_select_low_r :
                      hit_p4hi ? fourth_port_select_high_r :
                      port_function_select_pkg::UNMAPPED_READ;

   // R9: selects clear on reset
   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         first_port_select_low_r <= port_function_select_pkg::SELECT_RESET;
         first_port_select_high_r <= port_function_select_pkg::SELECT_RESET;
         third_port_select_r <= port_function_select_pkg::SELECT_RESET;
         fourth_port_select_low_r <= port_function_select_pkg::SELECT_RESET;
         fourth_port_select_high_r <= port_function_select_pkg::SELECT_RESET;
      end
      else if (SFR_WR_IN) begin
         // R11: write stores value
         if (hit_p1lo) first_port_select_low_r <= SFR_WDATA_IN;
         if (hit_p1hi) first_port_select_high_r <= SFR_WDATA_IN;
         if (hit_p3) third_port_select_r <= SFR_WDATA_IN;
         if (hit_p4lo) fourth_port_select_low_r <= SFR_WDATA_IN;
         if (hit_p4hi) fourth_port_select_high_r <= SFR_WDATA_IN;
      end
   end

   // R11: registered read-back
   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         SFR_RDATA_OUT <= 8'h00;
      end
      else if (SFR_RD_IN) begin
         SFR_RDATA_OUT <= rdata_nxt;
      end
   end

   // -------------------------------------------------------------
   // routing per port
   // -------------------------------------------------------------
   // R3: first port two-bit select
   // R4: alt one is timer two, uart b, serial peripheral
   // R5: alt two disables drive and enables analog channel
   port_route u_port1 (
      .clk_in(REF_CLK_IN),
      .rst_n_in(rst_n),
      .sel_lo_in(first_port_select_low_r),
      .sel_hi_in(first_port_select_high_r),
      .pin_in(pin_sync_r[7:0]),
      .pin_out(PIN1_OUT),
      .pin_oe_out(PIN1_OE_OUT),
      .gpio_out_in(GPIO1_OUT_IN),
      .gpio_oe_in(GPIO1_OE_IN),
      .gpio_in_out(GPIO1_PIN_OUT),
      .a1_out_in(ALT1A_OUT_IN),
      .a1_oe_in(ALT1A_OE_IN),
      .a1_in_out(ALT1A_PIN_OUT),
      .a2_out_in(8'h00),
      .a2_oe_in(8'h00),
      .a2_in_out(),
      .a2_active_out(ANALOG_CHANNEL_EN_OUT)
   );

   // R1: one bit per pin, high selects alternate
   // R2: alternate set for the third port
   port_route u_port3 (
      .clk_in(REF_CLK_IN),
      .rst_n_in(rst_n),
      .sel_lo_in(third_port_select_r),
      .sel_hi_in(8'h00),
      .pin_in(pin_sync_r[15:8]),
      .pin_out(PIN3_OUT),
      .pin_oe_out(PIN3_OE_OUT),
      .gpio_out_in(GPIO3_OUT_IN),
      .gpio_oe_in(GPIO3_OE_IN),
      .gpio_in_out(GPIO3_PIN_OUT),
      .a1_out_in(ALT3_OUT_IN),
      .a1_oe_in(ALT3_OE_IN),
      .a1_in_out(ALT3_PIN_OUT),
      .a2_out_in(8'h00),
      .a2_oe_in(8'h00),
      .a2_in_out(),
      .a2_active_out()
   );

   // R6: same two-bit select as first port
   // R7: alt one is counter array pins
   // R8: alt two is timer two, uart b, serial peripheral
   port_route u_port4 (
      .clk_in(REF_CLK_IN),
      .rst_n_in(rst_n),
      .sel_lo_in(fourth_port_select_low_r),
      .sel_hi_in(fourth_port_select_high_r),
      .pin_in(pin_sync_r[23:16]),
      .pin_out(PIN4_OUT),
      .pin_oe_out(PIN4_OE_OUT),
      .gpio_out_in(GPIO4_OUT_IN),
      .gpio_oe_in(GPIO4_OE_IN),
      .gpio_in_out(GPIO4_PIN_OUT),
      .a1_out_in(ALT4A_OUT_IN),
      .a1_oe_in(ALT4A_OE_IN),
      .a1_in_out(ALT4A_PIN_OUT),
      .a2_out_in(ALT4B_OUT_IN),
      .a2_oe_in(ALT4B_OE_IN),
      .a2_in_out(ALT4B_PIN_OUT),
      .a2_active_out()
   );

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   logic past_ok_r;

   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         past_ok_r <= 1'b0;
      end
      else begin
         past_ok_r <= 1'b1;
      end
   end

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (!rst_n);

   sequence p3_write_s;
      SFR_WR_IN && hit_p3;
   endsequence

   sequence read_s;
      SFR_RD_IN;
   endsequence

   a_p3_drive_route: assert property (past_ok_r |-> PIN3_OE_OUT ==
      $past((third_port_select_r & ALT3_OE_IN) | (~third_port_select_r & GPIO3_OE_IN))) // R1
      else $error("third port drive enable misrouted");

   a_p3_alt_input: assert property (past_ok_r |-> ALT3_PIN_OUT ==
      $past(~third_port_select_r | pin_sync_r[15:8])) // R2
      else $error("third port alternate input misrouted");

   a_p1_gpio_mode: assert property (past_ok_r |-> ((PIN1_OUT & ~$past(first_port_select_low_r)) ==
      ($past(GPIO1_OUT_IN) & ~$past(first_port_select_low_r)))) // R3
      else $error("first port general-purpose pin misrouted");

   a_p1_alt1_input: assert property (past_ok_r |-> ALT1A_PIN_OUT ==
      $past(~(first_port_select_low_r & ~first_port_select_high_r) | pin_sync_r[7:0])) // R4
      else $error("first port alternate one input misrouted");

   a_analog_enable: assert property (past_ok_r |-> (ANALOG_CHANNEL_EN_OUT ==
      $past(first_port_select_low_r & first_port_select_high_r))
      && ((PIN1_OE_OUT & ANALOG_CHANNEL_EN_OUT) == 8'h00)) // R5
      else $error("analog channel enable wrong or pin driven");

   a_p4_alt1_drive: assert property (past_ok_r |-> ((PIN4_OE_OUT &
      $past(fourth_port_select_low_r & ~fourth_port_select_high_r)) ==
      $past(ALT4A_OE_IN & fourth_port_select_low_r & ~fourth_port_select_high_r))) // R6 R7
      else $error("fourth port alternate one drive misrouted");

   a_p4_alt2_input: assert property (past_ok_r |-> ALT4B_PIN_OUT ==
      $past(~(fourth_port_select_low_r & fourth_port_select_high_r) | pin_sync_r[23:16])) // R8
      else $error("fourth port alternate two input misrouted");

   a_reset_clear: assert property (!past_ok_r |-> (first_port_select_low_r | first_port_select_high_r
      | third_port_select_r | fourth_port_select_low_r | fourth_port_select_high_r) == 8'h00) // R9
      else $error("select register not clear after reset");

   a_write_readback: assert property (p3_write_s ##1 !(SFR_WR_IN && hit_p3) ##1 (read_s and hit_p3) |=>
      SFR_RDATA_OUT == $past(SFR_WDATA_IN, 3)) // R11
      else $error("third port select did not read back written value");

   a_read_unmapped: assert property (read_s and !(hit_p1lo || hit_p1hi || hit_p3 || hit_p4lo || hit_p4hi)
      |=> SFR_RDATA_OUT == 8'h00) // R11
      else $error("unmapped read not zero");

endmodule

// >>> tb/board_pin_model.sv
// board_pin_model: pads of the three ports with board drivers and pull-ups
// assumes: three 8-bit ports packed {fourth, third, first}; pads are purely combinational

`timescale 1ns/1ps

module board_pin_model (
   // design side
   input wire logic [23:0] out_in,
   input wire logic [23:0] oe_in,
   // board side
   input wire logic [23:0] ext_in,
   input wire logic [23:0] ext_en_in,
   output logic [23:0] level_out
);
   // ------------------------------------------------------------
   // pad resolution
   // ------------------------------------------------------------
   // a pad nobody drives floats up to the pull-up level
   assign level_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_in) | (~oe_in & ~ext_en_in);
endmodule

// >>> tb/port_function_select_mux_bench.sv
// port_function_select_mux_bench: select register and pin routing checks
// assumes: board_pin_model closes the pad loop; inputs change on the falling edge

`timescale 1ns/1ps

module port_function_select_mux_bench;
   localparam logic [7:0] IDLE = {8{port_function_select_pkg::ALT_IDLE_LEVEL}};
   localparam logic [7:0] ADR [5] = '{port_function_select_pkg::FIRST_PORT_SELECT_LOW_ADDR,
      port_function_select_pkg::FIRST_PORT_SELECT_HIGH_ADDR, port_function_select_pkg::THIRD_PORT_SELECT_ADDR,
      port_function_select_pkg::FOURTH_PORT_SELECT_LOW_ADDR, port_function_select_pkg::FOURTH_PORT_SELECT_HIGH_ADDR};
   localparam logic [7:0] BASE [18] = '{8'ha5, 8'h0f, 8'h3c, 8'hf0, 8'h69, 8'h33, 8'hc6, 8'hcc,
      8'h5a, 8'h55, 8'h96, 8'h0f, 8'he1, 8'hf0, 8'h4b, 8'hb4, 8'h2d, 8'h77};
   localparam logic [39:0] ROWS [5] = '{40'h0f03c3f1f0, 40'h00ff3c00ff, 40'hff00ffff0f,
      40'hffff010fff, 40'ha55a805aa5};
   logic REF_CLK_IN = 1'b0;
   logic RST_N_IN = 1'b0;
   logic [7:0] addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] drv [18];
   logic [7:0] sel [5];
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   wire logic [7:0] rdata, p1o, p1e, g1p, a1p, an, p3o, p3e, g3p, a3p, p4o, p4e, g4p, a4p, b4p;
   wire logic [23:0] pad;

   port_function_select_mux port_function_select_mux_i (
      .REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
      .SFR_ADDR_IN(addr), .SFR_WR_IN(sfr_wr), .SFR_RD_IN(sfr_rd), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata),
      .PIN1_IN(pad[7:0]), .PIN1_OUT(p1o), .PIN1_OE_OUT(p1e), .GPIO1_OUT_IN(drv[0]), .GPIO1_OE_IN(drv[1]),
      .GPIO1_PIN_OUT(g1p), .ALT1A_OUT_IN(drv[2]), .ALT1A_OE_IN(drv[3]), .ALT1A_PIN_OUT(a1p),
      .ANALOG_CHANNEL_EN_OUT(an),
      .PIN3_IN(pad[15:8]), .PIN3_OUT(p3o), .PIN3_OE_OUT(p3e), .GPIO3_OUT_IN(drv[4]), .GPIO3_OE_IN(drv[5]),
      .GPIO3_PIN_OUT(g3p), .ALT3_OUT_IN(drv[6]), .ALT3_OE_IN(drv[7]), .ALT3_PIN_OUT(a3p),
      .PIN4_IN(pad[23:16]), .PIN4_OUT(p4o), .PIN4_OE_OUT(p4e), .GPIO4_OUT_IN(drv[8]), .GPIO4_OE_IN(drv[9]),
      .GPIO4_PIN_OUT(g4p), .ALT4A_OUT_IN(drv[10]), .ALT4A_OE_IN(drv[11]), .ALT4A_PIN_OUT(a4p),
      .ALT4B_OUT_IN(drv[12]), .ALT4B_OE_IN(drv[13]), .ALT4B_PIN_OUT(b4p)
   );

   board_pin_model board_pin_model_i (
      .out_in({p4o, p3o, p1o}), .oe_in({p4e, p3e, p1e}),
      .ext_in({drv[16], drv[15], drv[14]}), .ext_en_in({3{drv[17]}}), .level_out(pad)
   );

   initial begin
      forever #5 REF_CLK_IN = ~REF_CLK_IN;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] pick(input logic [7:0] lo, hi, g, a, b);
      return (~lo & g) | (lo & ~hi & a) | (lo & hi & b);
   endfunction

   task automatic final_report();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      @(negedge REF_CLK_IN);
      addr = a;
      wdata = d;
      sfr_wr = 1'b1;
      @(negedge REF_CLK_IN);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, exp);
      @(negedge REF_CLK_IN);
      addr = a;
      sfr_rd = 1'b1;
      @(negedge REF_CLK_IN);
      sfr_rd = 1'b0;
      chk(rdata, exp);
   endtask

   task automatic do_reset();
      @(negedge REF_CLK_IN);
      RST_N_IN = 1'b0;
      repeat (20) @(negedge REF_CLK_IN);
      RST_N_IN = 1'b1;
      repeat (3) @(negedge REF_CLK_IN);
   endtask

   task automatic setin(input logic [7:0] m);
      for (int i = 0; i < 18; i++) drv[i] = BASE[i] ^ m;
   endtask

   task automatic apply(input logic [39:0] r);
      for (int i = 0; i < 5; i++) begin
         sel[i] = r[39 - 8 * i -: 8];
         wr(ADR[i], sel[i]);
      end
      repeat (6) @(negedge REF_CLK_IN);
   endtask

   task automatic port_chk(input logic [7:0] lo, hi, go, ge, ao, ae, bo, be, x, po, pe, gp, ap,
                           output logic [7:0] w);
      logic [7:0] eo;
      logic [7:0] ee;
      eo = pick(lo, hi, go, ao, bo);
      ee = pick(lo, hi, ge, ae, be);
      w = (ee & eo) | (~ee & drv[17] & x) | (~ee & ~drv[17]);
      chk(pe, ee); // enables per pin
      chk(po & ee, eo & ee); // driven values per pin
      chk(gp, w); // port read path
      chk(ap, pick(lo, hi, IDLE, w, IDLE)); // alternate one input
   endtask

   task automatic check_all();
      logic [7:0] w;
      port_chk(sel[0], sel[1], drv[0], drv[1], drv[2], drv[3], 8'h00, 8'h00, drv[14], p1o, p1e, g1p, a1p, w);
      chk(an, sel[0] & sel[1]); // analog routing
      port_chk(sel[2], 8'h00, drv[4], drv[5], drv[6], drv[7], 8'h00, 8'h00, drv[15], p3o, p3e, g3p, a3p, w);
      port_chk(sel[3], sel[4], drv[8], drv[9], drv[10], drv[11], drv[12], drv[13], drv[16], p4o, p4e, g4p, a4p,
               w); // fourth port
      chk(b4p, pick(sel[3], sel[4], IDLE, IDLE, w)); // alternate two input
   endtask

   always @(posedge REF_CLK_IN) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      setin(8'h00);
      for (int i = 0; i < 5; i++) sel[i] = 8'h00;
      do_reset();
      for (int i = 0; i < 5; i++) rd(ADR[i], port_function_select_pkg::SELECT_RESET); // reset value
      check_all(); // all pins general purpose
      for (int i = 0; i < 5; i++) wr(ADR[i], 8'h5a ^ ADR[i]);
      for (int i = 0; i < 5; i++) rd(ADR[i], 8'h5a ^ ADR[i]); // readback
      wr(8'h90, 8'hff);
      rd(8'h90, port_function_select_pkg::UNMAPPED_READ); // unmapped read
      rd(ADR[0], 8'h5a ^ ADR[0]); // unmapped write ignored
      wr(ADR[2], 8'h3c);
      rd(ADR[2], 8'h3c); // read straight after write
      apply(40'h0);
      wr(ADR[2], 8'hc3);
      sel[2] = 8'hc3;
      chk(p3e, drv[5]); // old routing before next edge
      @(negedge REF_CLK_IN);
      chk(p3e, pick(8'hc3, 8'h00, drv[5], drv[7], 8'h00)); // new routing one edge on
      for (int p = 0; p < 2; p++) begin
         setin(p == 0 ? 8'h00 : 8'hff);
         for (int r = 0; r < 5; r++) begin
            apply(ROWS[r]);
            check_all(); // mixed selections
         end
      end
      do_reset();
      for (int i = 0; i < 5; i++) begin
         sel[i] = 8'h00;
         rd(ADR[i], port_function_select_pkg::SELECT_RESET); // mid-run reset
      end
      check_all(); // back to general purpose
      final_report();
   end
endmodule
